// file: iwr_pkg.sv
// constants for the independent watchdog register block
// assumes a 10 MHz system clock and a low-speed oscillator modelled as an enable
package iwr_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned OSC_HZ        = 32_000;
  // oscillator period rounded down to whole system cycles
  localparam int unsigned OSC_DIV       = CLK_HZ / OSC_HZ;
  // oscillator ticks between an accepted write and its arrival (limit is five)
  localparam int unsigned XFER_TICKS    = 2;

  localparam logic [31:0] OFS_KEY       = 32'h0000_0000;
  localparam logic [31:0] OFS_DIV_SEL   = 32'h0000_0004;
  localparam logic [31:0] OFS_RELOAD    = 32'h0000_0008;
  localparam logic [31:0] OFS_STATUS    = 32'h0000_000C;
  localparam logic [31:0] OFS_WINDOW    = 32'h0000_0010;

  localparam logic [15:0] KEY_UNLOCK    = 16'h5555;
  localparam logic [15:0] KEY_REFRESH   = 16'hAAAA;
  localparam logic [15:0] KEY_START     = 16'hCCCC;

  localparam logic [2:0]  RST_DIV_SEL   = 3'h0;
  localparam logic [11:0] RST_RELOAD    = 12'hFFF;
  localparam logic [11:0] RST_WINDOW    = 12'hFFF;
  localparam logic [11:0] RST_COUNTER   = 12'hFFF;
  localparam logic [2:0]  DIV_SEL_MAX   = 3'h6;
  localparam logic [7:0]  DIV_BASE      = 8'h04;

  // status bit positions
  localparam int unsigned ST_DIV        = 0;
  localparam int unsigned ST_RELOAD     = 1;
  localparam int unsigned ST_WINDOW     = 2;

  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

endpackage

// file: iwr_top.sv
// independent watchdog: registers, oscillator-domain copies and downcounter
// assumes an AXI4-Lite master, synchronous inputs and a single system clock
//
// Design decision made here: the AXI4-Lite interface to the registers.
module iwr_top
  import iwr_pkg::*;
#(
  parameter bit WINDOW_OPT = 1'b1          // build option for the window feature
) (
  input  wire logic        clk_i,          // system clock
  input  wire logic        resetn_i,       // async reset, active low
  input  wire logic        standby_i,      // standby entry, level
  input  wire logic [31:0] awaddr_i,       // write address
  input  wire logic        awvalid_i,      // write address valid
  output logic             awready_o,      // write address ready
  input  wire logic [31:0] wdata_i,        // write data
  input  wire logic [3:0]  wstrb_i,        // write byte strobes
  input  wire logic        wvalid_i,       // write data valid
  output logic             wready_o,       // write data ready
  output logic [1:0]       bresp_o,        // write response
  output logic             bvalid_o,       // write response valid
  input  wire logic        bready_i,       // write response ready
  input  wire logic [31:0] araddr_i,       // read address
  input  wire logic        arvalid_i,      // read address valid
  output logic             arready_o,      // read address ready
  output logic [31:0]      rdata_o,        // read data
  output logic [1:0]       rresp_o,        // read response
  output logic             rvalid_o,       // read data valid
  input  wire logic        rready_i,       // read data ready
  output logic             wdog_reset_o    // watchdog reset request, sticky
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_held_q, w_held_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic        wr_fire;

  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_q <= 1'b0;
      awready_q <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
    end else begin
      awready_q <= !aw_held_q && !(awvalid_i && awready_q);
      if (awvalid_i && awready_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= awaddr_i;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_held_q <= 1'b0;
      wready_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      wready_q <= !w_held_q && !(wvalid_i && wready_q);
      if (wvalid_i && wready_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= wdata_i;
        wstrb_q  <= wstrb_i;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // unmapped addresses answer slave error; the status register is read-only
  logic wr_mapped;
  assign wr_mapped = (awaddr_q == OFS_KEY) || (awaddr_q == OFS_DIV_SEL) ||
                     (awaddr_q == OFS_RELOAD) || (awaddr_q == OFS_WINDOW);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key decode and protection

  logic        unlocked_q, running_q;
  logic        key_wr, refresh_req;
  logic [15:0] wr_lo;
  logic [2:0]  pend_q;

  assign wr_lo  = wdata_q[15:0];
  assign key_wr = wr_fire && awaddr_q == OFS_KEY && wstrb_q[1:0] == 2'b11;
  assign refresh_req = key_wr && wr_lo == KEY_REFRESH;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      unlocked_q <= 1'b0;
    end else if (standby_i) begin
      unlocked_q <= 1'b0;
    end else if (key_wr) begin
      unlocked_q <= (wr_lo == KEY_UNLOCK);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      running_q <= 1'b0;
    end else if (key_wr && wr_lo == KEY_START) begin
      running_q <= 1'b1;
    end
  end

  // a write lands only when unlocked and that field has no transfer in flight
  logic wr_div, wr_rel, wr_win;
  assign wr_div = wr_fire && unlocked_q && awaddr_q == OFS_DIV_SEL
                  && wstrb_q[0] && !pend_q[ST_DIV];
  assign wr_rel = wr_fire && unlocked_q && awaddr_q == OFS_RELOAD
                  && wstrb_q[1:0] != 2'b00 && !pend_q[ST_RELOAD];
  assign wr_win = WINDOW_OPT && wr_fire && unlocked_q && awaddr_q == OFS_WINDOW
                  && wstrb_q[1:0] != 2'b00 && !pend_q[ST_WINDOW];

  ////////////////////////////////////////////////////////////////////////////
  // staging values and oscillator-domain copies

  logic [2:0]  div_stage_q, div_copy_q;
  logic [11:0] rel_stage_q, rel_copy_q, win_stage_q, win_copy_q;
  logic [11:0] rel_merge, win_merge;

  assign rel_merge = {wstrb_q[1] ? wdata_q[11:8] : rel_stage_q[11:8],
                      wstrb_q[0] ? wdata_q[7:0]  : rel_stage_q[7:0]};
  assign win_merge = {wstrb_q[1] ? wdata_q[11:8] : win_stage_q[11:8],
                      wstrb_q[0] ? wdata_q[7:0]  : win_stage_q[7:0]};

  logic        osc_tick_q;
  logic [15:0] osc_cnt_q;
  logic [1:0]  xfer_cnt_q [3];
  logic [2:0]  land;
  logic [2:0]  wr_acc;

  assign wr_acc = {wr_win, wr_rel, wr_div};

  // low-speed oscillator modelled as a one-cycle enable
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_cnt_q  <= 16'h0000;
      osc_tick_q <= 1'b0;
    end else begin
      osc_tick_q <= (osc_cnt_q == 16'(OSC_DIV - 1));
      osc_cnt_q  <= (osc_cnt_q == 16'(OSC_DIV - 1)) ? 16'h0000 : osc_cnt_q + 16'h0001;
    end
  end

  // pending flags: set by the write, cleared on the oscillator tick that lands it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_q     <= 3'b000;
      xfer_cnt_q <= '{default: 2'b00};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_acc[i]) begin
          pend_q[i]     <= 1'b1;
          xfer_cnt_q[i] <= 2'b00;
        end else if (pend_q[i] && osc_tick_q) begin
          xfer_cnt_q[i] <= xfer_cnt_q[i] + 2'b01;
          if (land[i]) begin
            pend_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      land[i] = pend_q[i] && osc_tick_q && xfer_cnt_q[i] == 2'(XFER_TICKS - 1);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_stage_q <= RST_DIV_SEL;
      div_copy_q  <= RST_DIV_SEL;
    end else begin
      if (wr_div) begin
        div_stage_q <= wdata_q[2:0];
      end
      if (land[ST_DIV]) begin
        div_copy_q <= div_stage_q;
      end
    end
  end

  // standby returns reload and window to their reset values, status survives
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rel_stage_q <= RST_RELOAD;
      rel_copy_q  <= RST_RELOAD;
      win_stage_q <= RST_WINDOW;
      win_copy_q  <= RST_WINDOW;
    end else if (standby_i) begin
      rel_stage_q <= RST_RELOAD;
      rel_copy_q  <= RST_RELOAD;
      win_stage_q <= RST_WINDOW;
      win_copy_q  <= RST_WINDOW;
    end else begin
      if (wr_rel) begin
        rel_stage_q <= rel_merge;
      end
      if (land[ST_RELOAD]) begin
        rel_copy_q <= rel_stage_q;
      end
      if (wr_win) begin
        win_stage_q <= win_merge;
      end
      if (land[ST_WINDOW]) begin
        win_copy_q <= win_stage_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and downcounter

  logic [7:0]  pre_cnt_q, pre_ratio;
  logic [11:0] count_q;
  logic        refresh_pend_q, step;

  assign pre_ratio = DIV_BASE << ((div_copy_q > DIV_SEL_MAX) ? DIV_SEL_MAX : div_copy_q);
  assign step      = osc_tick_q && pre_cnt_q == pre_ratio - 8'h01;

  // refresh held until the next oscillator tick, where the counter lives
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      refresh_pend_q <= 1'b0;
    end else if (refresh_req) begin
      refresh_pend_q <= 1'b1;
    end else if (osc_tick_q) begin
      refresh_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_cnt_q <= 8'h00;
      count_q   <= RST_COUNTER;
    end else if (running_q && osc_tick_q) begin
      if (refresh_pend_q || land[ST_WINDOW]) begin
        count_q   <= rel_copy_q;
        pre_cnt_q <= 8'h00;
      end else if (step) begin
        pre_cnt_q <= 8'h00;
        if (count_q != 12'h000) begin
          count_q <= count_q - 12'h001;
        end
      end else begin
        pre_cnt_q <= pre_cnt_q + 8'h01;
      end
    end
  end

  // refresh outside the window or reaching zero ends in a watchdog reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdog_reset_o <= 1'b0;
    end else if (running_q) begin
      if (count_q == 12'h000) begin
        wdog_reset_o <= 1'b1;
      end
      if (osc_tick_q && refresh_pend_q && count_q > win_copy_q) begin
        wdog_reset_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= !rvalid_q && !(arvalid_i && arready_q);
      if (arvalid_i && arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        unique case (araddr_i)
          OFS_KEY:     rdata_q <= 32'h0000_0000;
          OFS_DIV_SEL: rdata_q <= {29'h0, div_copy_q};
          OFS_RELOAD:  rdata_q <= {20'h0, rel_copy_q};
          OFS_STATUS:  rdata_q <= {29'h0, pend_q[2] & WINDOW_OPT, pend_q[1:0]};
          OFS_WINDOW:  rdata_q <= {20'h0, win_copy_q};
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end else if (rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign awready_o = awready_q;
  assign wready_o  = wready_q;
  assign bvalid_o  = bvalid_q;
  assign bresp_o   = bresp_q;
  assign arready_o = arready_q;
  assign rvalid_o  = rvalid_q;
  assign rdata_o   = rdata_q;
  assign rresp_o   = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  logic [15:0] pend_age_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_age_q <= 16'h0000;
    end else begin
      pend_age_q <= pend_q[ST_RELOAD] ? pend_age_q + 16'h0001 : 16'h0000;
    end
  end

  a_div_locked: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_fire && awaddr_q == OFS_DIV_SEL && !unlocked_q) |=> $stable(div_stage_q))
    else $error("divider staged while locked");
  a_div_pending: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (pend_q[ST_DIV] && !land[ST_DIV]) |=> $stable(div_stage_q) && pend_q[ST_DIV])
    else $error("divider changed during transfer");
  a_pend_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_rel |=> pend_q[ST_RELOAD])
    else $error("reload pending not set");
  a_reload_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pend_age_q <= 16'(5 * OSC_DIV))
    else $error("reload transfer too long");
  a_reload_lands: assert property (@(posedge clk_i) disable iff (!resetn_i || standby_i)
    $fell(pend_q[ST_RELOAD]) |-> rel_copy_q == rel_stage_q)
    else $error("reload copy not landed");
  a_win_option: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !WINDOW_OPT |-> !pend_q[ST_WINDOW])
    else $error("window pending without option");
  a_refresh_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (running_q && osc_tick_q && refresh_pend_q && !standby_i) |=> count_q == $past(rel_copy_q))
    else $error("refresh did not reload");
  a_zero_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (running_q && count_q == 12'h000) |=> wdog_reset_o)
    else $error("no reset at zero");
  // a transfer may still land during standby; only a landing may drop a flag
  a_standby_vals: assert property (@(posedge clk_i) disable iff (!resetn_i)
    standby_i |=> rel_copy_q == RST_RELOAD && win_copy_q == RST_WINDOW
                  && ($past(pend_q) & ~pend_q & ~$past(land)) == 3'b000)
    else $error("standby values wrong");
  a_early_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (running_q && osc_tick_q && refresh_pend_q && count_q > win_copy_q) |=> wdog_reset_o)
    else $error("early refresh not caught");

endmodule

// file: tb_independent_watchdog_regs.sv
// self-checking bench for the watchdog register block over its bus port
// assumes iwr_top with the window option on and the package's oscillator ratio
module tb_independent_watchdog_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import iwr_pkg::*;

  typedef struct {
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0]  resp;
  } iwr_row_type;
  typedef struct {
    logic [31:0] addr;
    int          bitpos;
    logic [31:0] old;
    logic [31:0] first;
    logic [31:0] second;
  } iwr_xfer_type;

  logic        clk_i     = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        standby_i = 1'b0;
  logic [31:0] awaddr_i  = 32'h0000_0000;
  logic        awvalid_i = 1'b0;
  logic [31:0] wdata_i   = 32'h0000_0000;
  logic [3:0]  wstrb_i   = 4'hf;
  logic        wvalid_i  = 1'b0;
  logic        bready_i  = 1'b0;
  logic [31:0] araddr_i  = 32'h0000_0000;
  logic        arvalid_i = 1'b0;
  logic        rready_i  = 1'b0;
  logic        awready_o;
  logic        wready_o;
  logic [1:0]  bresp_o;
  logic        bvalid_o;
  logic        arready_o;
  logic [31:0] rdata_o;
  logic [1:0]  rresp_o;
  logic        rvalid_o;
  logic        wdog_reset_o;
  int          fails = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  iwr_row_type rst_rows [6] = '{
    '{OFS_KEY,      32'h0000_0000, RESP_OKAY},
    '{OFS_DIV_SEL,  32'h0000_0000, RESP_OKAY},
    '{OFS_RELOAD,   32'h0000_0fff, RESP_OKAY},
    '{OFS_STATUS,   32'h0000_0000, RESP_OKAY},
    '{OFS_WINDOW,   32'h0000_0fff, RESP_OKAY},
    '{32'h0000_0014, 32'h0000_0000, RESP_SLVERR}};
  iwr_xfer_type xfer_rows [3] = '{
    '{OFS_DIV_SEL, 0, 32'h0000_0000, 32'h0000_0003, 32'h0000_0005},
    '{OFS_RELOAD,  1, 32'h0000_0fff, 32'h0000_0234, 32'h0000_0456},
    '{OFS_WINDOW,  2, 32'h0000_0fff, 32'h0000_0345, 32'h0000_0567}};

  iwr_top iwr_top_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .standby_i(standby_i),
    .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
    .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
    .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .wdog_reset_o(wdog_reset_o)
  );

  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask

  // address and data offered together; bready lowered one edge before the next raise
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    r     = 2'b11;
    awaddr_i  <= a;
    wdata_i   <= d;
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    bready_i  <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (aw_ok && w_ok && bvalid_o === 1'b1) begin
        r = bresp_o;
        break;
      end
      if (!aw_ok && awready_o === 1'b1) begin
        aw_ok = 1'b1;
        awvalid_i <= 1'b0;
      end
      if (!w_ok && wready_o === 1'b1) begin
        w_ok = 1'b1;
        wvalid_i <= 1'b0;
      end
    end
    bready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok;
    ar_ok = 1'b0;
    d     = 32'hdead_beef;
    r     = 2'b11;
    araddr_i  <= a;
    arvalid_i <= 1'b1;
    rready_i  <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (ar_ok && rvalid_o === 1'b1) begin
        d = rdata_o;
        r = rresp_o;
        break;
      end
      if (!ar_ok && arready_o === 1'b1) begin
        ar_ok = 1'b1;
        arvalid_i <= 1'b0;
      end
    end
    rready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // polls status; the clear must come within five oscillator periods
  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0]  r;
    int          t0;
    t0 = cyc;
    d  = 32'h0000_0007;
    while (d !== 32'h0000_0000 && cyc - t0 < 6 * OSC_DIV) axi_read(OFS_STATUS, d, r);
    check("pending clear time", 32'(cyc - t0 <= 5 * OSC_DIV), 32'h0000_0001);
  endtask

  task automatic wait_wdog(input int lim, output int took);
    took = 0;
    while (wdog_reset_o !== 1'b1 && took < lim) begin
      @(posedge clk_i);
      took++;
    end
  endtask

  // fresh reset, counter started, unlocked, reload value landed
  task automatic arm(input logic [31:0] rl);
    logic [1:0] r;
    do_reset();
    axi_write(OFS_KEY, {16'h0000, KEY_START}, r);
    axi_write(OFS_KEY, {16'h0000, KEY_UNLOCK}, r);
    axi_write(OFS_RELOAD, rl, r);
    wait_idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          took;
    do_reset();
    foreach (rst_rows[i]) begin
      axi_read(rst_rows[i].addr, d, r);
      check("reset read data", d, rst_rows[i].data);
      check("reset read resp", 32'(r), 32'(rst_rows[i].resp));
    end
    axi_write(OFS_STATUS, 32'h0000_0007, r);
    check("status write resp", 32'(r), 32'(RESP_SLVERR));
    axi_write(OFS_DIV_SEL, 32'h0000_0005, r);
    check("locked write resp", 32'(r), 32'(RESP_OKAY));
    axi_read(OFS_STATUS, d, r);
    check("locked write pending", d, 32'h0000_0000);
    axi_read(OFS_DIV_SEL, d, r);
    check("locked divider", d, 32'h0000_0000);
    axi_write(OFS_KEY, {16'h0000, KEY_UNLOCK}, r);
    // second write, made while the first is still crossing, is dropped
    foreach (xfer_rows[i]) begin
      axi_write(xfer_rows[i].addr, xfer_rows[i].first, r);
      axi_read(OFS_STATUS, d, r);
      check("pending after write", d, 32'h0000_0001 << xfer_rows[i].bitpos);
      axi_read(xfer_rows[i].addr, d, r);
      check("copy before landing", d, xfer_rows[i].old);
      axi_write(xfer_rows[i].addr, xfer_rows[i].second, r);
      wait_idle();
      axi_read(xfer_rows[i].addr, d, r);
      check("write while pending", d, xfer_rows[i].first);
    end
    for (int c = 0; c < 8; c++) begin
      axi_write(OFS_DIV_SEL, 32'(c), r);
      wait_idle();
      axi_read(OFS_DIV_SEL, d, r);
      check("divider code", d, 32'(c));
    end
    axi_write(OFS_KEY, {16'h0000, KEY_REFRESH}, r);
    axi_write(OFS_DIV_SEL, 32'h0000_0002, r);
    axi_read(OFS_STATUS, d, r);
    check("relocked pending", d, 32'h0000_0000);
    axi_read(OFS_DIV_SEL, d, r);
    check("relocked divider", d, 32'h0000_0007);
    // standby while a reload is in flight: flag survives, fields return to all ones
    axi_write(OFS_KEY, {16'h0000, KEY_UNLOCK}, r);
    axi_write(OFS_RELOAD, 32'h0000_00ab, r);
    standby_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    standby_i <= 1'b0;
    axi_read(OFS_STATUS, d, r);
    check("status over standby", d, 32'h0000_0002);
    wait_idle();
    axi_read(OFS_RELOAD, d, r);
    check("reload after standby", d, 32'h0000_0fff);
    axi_read(OFS_WINDOW, d, r);
    check("window after standby", d, 32'h0000_0fff);
    // expiry: reload of 2 at divide-by-4 runs out in a few oscillator ticks
    arm(32'h0000_0002);
    axi_write(OFS_KEY, {16'h0000, KEY_REFRESH}, r);
    repeat (2 * OSC_DIV) @(posedge clk_i);
    check("early expiry", 32'(wdog_reset_o), 32'h0000_0000);
    wait_wdog(12 * OSC_DIV, took);
    check("expiry request", 32'(wdog_reset_o), 32'h0000_0001);
    check("expiry timing", 32'(took >= 2 * OSC_DIV && took <= 8 * OSC_DIV), 32'h0000_0001);
    // refresh above the window limit
    arm(32'h0000_0200);
    axi_write(OFS_WINDOW, 32'h0000_0100, r);
    wait_idle();
    check("no request before refresh", 32'(wdog_reset_o), 32'h0000_0000);
    axi_write(OFS_KEY, {16'h0000, KEY_REFRESH}, r);
    wait_wdog(4 * OSC_DIV, took);
    check("refresh above window", 32'(wdog_reset_o), 32'h0000_0001);
    // no refresh: only the window write landing can reload the counter with the reload value of 2
    arm(32'h0000_0002);
    axi_write(OFS_WINDOW, 32'h0000_0ffe, r);
    wait_wdog(12 * OSC_DIV, took);
    check("window change reload", 32'(wdog_reset_o), 32'h0000_0001);
    tally_and_finish();
  end

  // run needs about 15k cycles; four times that means a hang
  initial begin
    #(100 * 60000);
    fails++;
    tally_and_finish();
  end

endmodule
